//--- core/tsm_pkg.sv
/*
 Shared types and constants for the tile slice move block.
 Assumes one core clock and a pipeline that supplies decoded fields and operand values.
*/
package tsm_pkg;
   localparam int DEF_SVL_BITS = 256;
   localparam int MIN_SVL_BITS = 128;
   localparam int MAX_SVL_BITS = 2048;
   localparam int NUM_PRED_REGS = 8;
   localparam int NUM_IDX_REGS = 4;
   localparam int IDX_REG_W = 32;
   localparam int OFFSET_FIELD_W = 4;
   localparam int RSP_LATENCY_CYC = 1;
   localparam logic [2:0] IDX_REG_PREFIX = 3'h3;
   localparam logic [3:0] OFFSET_FULL_MASK = 4'hF;

   typedef enum logic [2:0] {ESZ_8, ESZ_16, ESZ_32, ESZ_64, ESZ_128, ESZ_BAD5, ESZ_BAD6, ESZ_BAD7} tsm_esize_e;

   typedef struct packed {
      logic valid;
      logic toTile;
      tsm_esize_e elemSize;
      logic vertical;
      logic [3:0] sourceTileSelect;
      logic [OFFSET_FIELD_W-1:0] offsetField;
      logic [1:0] indexRegSelectField;
      logic [2:0] predSel;
      logic [4:0] vecReg;
   } tsm_req_s;

   typedef struct packed {
      logic valid;
      logic undefinedInstr;
      logic accessTrap;
      logic vecWrEn;
      logic [4:0] vecWrReg;
      logic [4:0] idxRegNum;
   } tsm_rsp_s;

   localparam tsm_rsp_s RSP_RESET = '0;
endpackage : tsm_pkg

//--- core/tsm_slice_move.sv
/*
 Matrix tile array storage with single-cycle slice moves to and from a vector register.
 Assumes the pipeline presents operand values with the request and writes back the vector result.
*/
`timescale 1ns/1ns
`default_nettype none

// How it works
// - slice is index plus offset, modulo elements
// - offset limited to 128-bit segment elements
// - inactive vector elements keep old value
// - inactive slice elements keep old value
// - index register is 12 plus field
// - offset field width shrinks with element size
// - tile count depends on element size
// - predicate one of eight, bit one moves
// - direction zero row, one column
// - no matrix feature means undefined instruction
// - element count is vector length over size
// - index register read as unsigned 32-bit
// - timing fixed regardless of data or flags
// - exception response independent of data
// - five element size classes each direction
module tsm_slice_move #(
   parameter int SVL_BITS = tsm_pkg::DEF_SVL_BITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire tsm_pkg::tsm_req_s req,
   input wire logic matrixFeatureImpl,
   input wire logic streamingModeEn,
   input wire logic tileStorageEn,
   input wire logic [tsm_pkg::IDX_REG_W-1:0] sliceIndexRegs [tsm_pkg::NUM_IDX_REGS],
   input wire logic [SVL_BITS/8-1:0] predFile [tsm_pkg::NUM_PRED_REGS],
   input wire logic [SVL_BITS-1:0] srcVectorReg,
   input wire logic [SVL_BITS-1:0] oldDestVector,
   input wire logic [$clog2(SVL_BITS/8)-1:0] peekRow,
   output tsm_pkg::tsm_rsp_s rsp,
   output logic [SVL_BITS-1:0] destVectorReg,
   output logic [SVL_BITS-1:0] peekRowData
);
   localparam int BYTES = SVL_BITS / 8;
   localparam int RW = $clog2(BYTES);

   if (SVL_BITS < tsm_pkg::MIN_SVL_BITS || SVL_BITS > tsm_pkg::MAX_SVL_BITS ||
       (SVL_BITS & (SVL_BITS - 1)) != 0)
   begin : g_badSvl
      $error("SVL_BITS must be a power of two from 128 to 2048");
   end

   // first byte of the element holding byte b
   function automatic logic [RW-1:0] elemBase(input logic [RW-1:0] b, input logic [2:0] lg);
      return (b >> lg) << lg;
   endfunction : elemBase

   logic [BYTES-1:0][SVL_BITS-1:0] tile_q, tile_d;
   tsm_pkg::tsm_rsp_s rsp_q, rsp_d;
   logic [SVL_BITS-1:0] destVector_q, destVector_d;
   logic [SVL_BITS-1:0] peek_q, peek_d;

   logic [2:0] lg;
   logic [RW-1:0] ebMask, dimMask, tileIdx, slice, hRow;
   logic [tsm_pkg::OFFSET_FIELD_W-1:0] offset;
   logic [tsm_pkg::IDX_REG_W:0] sliceSum;
   logic [BYTES-1:0] pred;
   logic sizeOk, doMove;

   always_comb
   begin
      lg = req.elemSize;
      sizeOk = req.elemSize <= tsm_pkg::ESZ_128;
      ebMask = RW'((1 << lg) - 1);
      dimMask = RW'((BYTES >> lg) - 1);
      offset = req.offsetField & (tsm_pkg::OFFSET_FULL_MASK >> lg);
      tileIdx = RW'(req.sourceTileSelect) & ebMask;
      sliceSum = {1'h0, sliceIndexRegs[req.indexRegSelectField]} +
         (tsm_pkg::IDX_REG_W + 1)'(offset);
      slice = sliceSum[RW-1:0] & dimMask;
      hRow = (slice << lg) | tileIdx;
      pred = predFile[req.predSel];
      doMove = req.valid && matrixFeatureImpl && sizeOk && streamingModeEn && tileStorageEn;
   end

   always_comb
   begin
      logic [RW-1:0] row, col, srcB;
      logic hit;
      row = '0;
      col = '0;
      srcB = '0;
      hit = 1'h0;
      rsp_d = tsm_pkg::RSP_RESET;
      rsp_d.valid = req.valid;
      rsp_d.undefinedInstr = req.valid && (!matrixFeatureImpl || !sizeOk);
      rsp_d.accessTrap = req.valid && matrixFeatureImpl && sizeOk &&
         !(streamingModeEn && tileStorageEn);
      rsp_d.vecWrEn = doMove && !req.toTile;
      rsp_d.vecWrReg = req.vecReg;
      rsp_d.idxRegNum = {tsm_pkg::IDX_REG_PREFIX, req.indexRegSelectField};
      destVector_d = oldDestVector;
      tile_d = tile_q;
      for (int b = 0; b < BYTES; b++)
      begin
         if (req.vertical)
         begin
            row = elemBase(RW'(b), lg) | tileIdx;
            col = (slice << lg) | (RW'(b) & ebMask);
         end
         else
         begin
            row = hRow;
            col = RW'(b);
         end
         if (pred[elemBase(RW'(b), lg)])
            destVector_d[b*8 +: 8] = tile_q[row][col*8 +: 8];
      end
      if (doMove && req.toTile)
      begin
         for (int r = 0; r < BYTES; r++)
         begin
            for (int c = 0; c < BYTES; c++)
            begin
               if (req.vertical)
               begin
                  hit = ((RW'(r) & ebMask) == tileIdx) && ((RW'(c) >> lg) == slice);
                  srcB = elemBase(RW'(r), lg) | (RW'(c) & ebMask);
               end
               else
               begin
                  hit = RW'(r) == hRow;
                  srcB = RW'(c);
               end
               if (hit && pred[elemBase(srcB, lg)])
                  tile_d[r][c*8 +: 8] = srcVectorReg[srcB*8 +: 8];
            end
         end
      end
      if (!rsp_d.vecWrEn)
         destVector_d = destVector_q;
      peek_d = tile_q[peekRow];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tile_q <= '0;
         rsp_q <= tsm_pkg::RSP_RESET;
         destVector_q <= '0;
         peek_q <= '0;
      end
      else
      begin
         tile_q <= tile_d;
         rsp_q <= rsp_d;
         destVector_q <= destVector_d;
         peek_q <= peek_d;
      end
   end

   assign rsp = rsp_q;
   assign destVectorReg = destVector_q;
   assign peekRowData = peek_q;

   // helper state for the checks below
   logic [SVL_BITS-1:0] chkOld_q, chkKeep_q;
   logic [SVL_BITS-1:0] chkKeep_d;
   always_comb
   begin
      for (int b = 0; b < BYTES; b++)
         chkKeep_d[b*8 +: 8] = pred[elemBase(RW'(b), lg)] ? 8'h00 : 8'hFF;
   end
   always_ff @(posedge clk)
   begin
      chkOld_q <= oldDestVector;
      chkKeep_q <= chkKeep_d;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_FIXED_LATENCY: assert property (req.valid |=> rsp.valid ##1 (rsp.valid == $past(req.valid)))
      else $error("response not exactly one cycle after request");
   AST_UNDEF_NO_FEATURE: assert property (req.valid && !matrixFeatureImpl |=>
      rsp.undefinedInstr && !rsp.vecWrEn && $stable(tile_q))
      else $error("missing feature did not give undefined");
   AST_TRAP_DISABLED: assert property (req.valid && matrixFeatureImpl && sizeOk &&
      !(streamingModeEn && tileStorageEn) |=> rsp.accessTrap && !rsp.vecWrEn && tile_q == $past(tile_q))
      else $error("disabled mode did not trap or touched data");
   AST_IDX_REG_NUM: assert property (req.valid |=> rsp.idxRegNum == {3'h3, $past(req.indexRegSelectField)})
      else $error("index register number wrong");
   AST_VEC_INACTIVE_KEEP: assert property (rsp.vecWrEn |-> ((destVectorReg ^ chkOld_q) & chkKeep_q) == '0)
      else $error("inactive vector element changed");
   AST_TILE_NO_PRED: assert property (doMove && req.toTile && pred == '0 |=> tile_q == $past(tile_q))
      else $error("tile changed with all predicate bits clear");
   AST_HORIZ_ROW: assert property (doMove && !req.toTile && !req.vertical && pred == '1 |=>
      destVectorReg == $past(tile_q[hRow]))
      else $error("horizontal slice read wrong row");
   AST_BAD_SIZE: assert property (req.valid && !sizeOk |=> rsp.undefinedInstr && !rsp.accessTrap)
      else $error("bad size class not undefined");
   AST_SLICE_RANGE: assert property (req.valid |-> (slice & ~dimMask) == '0 && offset <= (4'hF >> lg))
      else $error("slice or offset out of range");
   AST_DEST_HOLD: assert property (!rsp.vecWrEn |-> $stable(destVectorReg))
      else $error("destination vector changed without a write");
   AST_TILE_READ_ONLY: assert property (doMove && !req.toTile |=> tile_q == $past(tile_q))
      else $error("tile changed by a tile to vector move");
   AST_NO_PRED_KEEP_VEC: assert property (doMove && !req.toTile && pred == '0 |=>
      destVectorReg == $past(oldDestVector))
      else $error("vector changed with all predicate bits clear");
   AST_IDLE_QUIET: assert property (!req.valid |=> !rsp.valid && $stable(tile_q))
      else $error("response or tile change without a request");
   AST_OFFSET_128: assert property (req.valid && req.elemSize == tsm_pkg::ESZ_128 |-> offset == '0)
      else $error("nonzero offset for 128-bit elements");

   COV_VERT_WRITE: cover property (doMove && req.toTile && req.vertical);
   COV_HORIZ_READ: cover property (doMove && !req.toTile && !req.vertical ##1 rsp.vecWrEn);
   COV_TRAP: cover property (rsp.accessTrap);
   COV_UNDEF: cover property (rsp.undefinedInstr);
   COV_VERT_READ: cover property (doMove && !req.toTile && req.vertical ##1 rsp.vecWrEn);
endmodule : tsm_slice_move

`default_nettype wire

//--- test/testbench.sv
/*
 Random back-to-back slice moves checked against a byte-level model.
 Assumes tsm_pkg, tsm_slice_move and tsm_pipe_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int SV = 128;
   logic clk = 1'h0, rst = 1'h1, impl = 1'h1, strmEn = 1'h1, storEn = 1'h1;
   tsm_pkg::tsm_req_s req = '0;
   logic [31:0] wr [4] = '{default: '0};
   logic [SV/8-1:0] pf [8] = '{default: '0};
   logic [SV-1:0] src = '0, old, dv, pk, edv = '0, epk = '0;
   logic [SV-1:0] mt [16] = '{default: '0}, vr [4] = '{default: '0};
   logic [3:0] pr = 4'h0;
   tsm_pkg::tsm_rsp_s rsp, ersp = '0, em = '1;
   logic [31:0] seed = 32'h0000DC7B;
   int n_mismatch = 0, tests_run = 0;
   always #50 clk = ~clk;
   tsm_slice_move #(.SVL_BITS(SV)) u_dut (.clk(clk), .rst(rst), .req(req), .matrixFeatureImpl(impl),
      .streamingModeEn(strmEn), .tileStorageEn(storEn), .sliceIndexRegs(wr), .predFile(pf), .srcVectorReg(src),
      .oldDestVector(old), .peekRow(pr), .rsp(rsp), .destVectorReg(dv), .peekRowData(pk));
   tsm_pipe_model #(.SVL_BITS(SV)) u_pipe (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .destVectorReg(dv),
      .oldDestVector(old));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk_rsp(tsm_pkg::tsm_rsp_s exp, tsm_pkg::tsm_rsp_s got, tsm_pkg::tsm_rsp_s msk);
      tests_run++;
      if ((got & msk) !== (exp & msk))
      begin
         n_mismatch++;
         $display("[FAIL] rsp expected %h seen %h", exp & msk, got & msk);
      end
   endtask : chk_rsp
   task automatic chk_vec(string what, logic [SV-1:0] exp, logic [SV-1:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_vec
   // drive one request; check the one taken at the previous edge
   task automatic go(tsm_pkg::tsm_req_s r, logic [3:0] p);
      int eb, dim, s, t, rr, c;
      logic [SV-1:0] nv;
      req <= r;
      pr <= p;
      @(negedge clk);
      chk_rsp(ersp, rsp, em);
      chk_vec("dest", edv, dv);
      chk_vec("peek", epk, pk);
      epk = mt[p];
      ersp = '0;
      em = '1;
      ersp.vecWrReg = r.vecReg;
      ersp.idxRegNum = {3'h3, r.indexRegSelectField};
      if (r.valid)
      begin
         ersp.valid = 1'h1;
         ersp.undefinedInstr = !impl || r.elemSize > tsm_pkg::ESZ_128;
         ersp.accessTrap = !ersp.undefinedInstr && !(strmEn && storEn);
         ersp.vecWrEn = !ersp.undefinedInstr && !ersp.accessTrap && !r.toTile;
         em.vecWrReg = {5{ersp.vecWrEn}};
         em.idxRegNum = {5{!ersp.undefinedInstr && !ersp.accessTrap}};
         if (!ersp.undefinedInstr && !ersp.accessTrap)
         begin
            eb = 1 << r.elemSize;
            dim = SV / 8 / eb;
            s = (wr[r.indexRegSelectField] + (r.offsetField & (dim - 1))) & (dim - 1);
            t = r.sourceTileSelect & (eb - 1);
            nv = vr[r.vecReg[1:0]];
            for (int e = 0; e < dim; e++)
            begin
               rr = r.vertical ? e * eb + t : s * eb + t;
               c = r.vertical ? s : e;
               for (int b = 0; b < eb; b++)
                  if (pf[r.predSel][e * eb] && r.toTile)
                     mt[rr][(c * eb + b) * 8 +: 8] = src[(e * eb + b) * 8 +: 8];
                  else if (pf[r.predSel][e * eb])
                     nv[(e * eb + b) * 8 +: 8] = mt[rr][(c * eb + b) * 8 +: 8];
            end
            if (!r.toTile)
            begin
               vr[r.vecReg[1:0]] = nv;
               edv = nv;
            end
         end
      end
      @(posedge clk);
   endtask : go
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   initial
   begin
      #100000;
      n_mismatch++;
      end_of_test();
   end
   initial
   begin
      tsm_pkg::tsm_req_s r;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      for (int i = 0; i < 400; i++)
      begin
         r = tsm_pkg::tsm_req_s'(($bits(tsm_pkg::tsm_req_s))'(rnd()));
         r.valid = rnd() % 8 != 0;
         r.vecReg = 5'(rnd() % 4);
         if (rnd() % 8 != 0)
            r.elemSize = tsm_pkg::tsm_esize_e'(3'(rnd() % 5));
         impl <= rnd() % 16 != 0;
         strmEn <= rnd() % 16 != 0;
         storEn <= rnd() % 16 != 0;
         src <= {rnd(), rnd(), rnd(), rnd()};
         wr[rnd() % 4] <= rnd();
         // some predicates all clear or all set
         if (rnd() % 4 == 0)
            pf[rnd() % 8] <= {(SV / 8){rnd() % 2 == 1}};
         else
            pf[rnd() % 8] <= 16'(rnd());
         go(r, 4'(rnd()));
      end
      go('0, 4'h0);
      go('0, 4'h0);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire

//--- test/tsm_pipe_model.sv
/*
 Pipeline stand-in: four vector registers with same-cycle writeback forwarding.
 Assumes the result and its response arrive one cycle after each request.
*/
`timescale 1ns/1ns
`default_nettype none
module tsm_pipe_model #(
   parameter int SVL_BITS = tsm_pkg::DEF_SVL_BITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire tsm_pkg::tsm_req_s req,
   input wire tsm_pkg::tsm_rsp_s rsp,
   input wire logic [SVL_BITS-1:0] destVectorReg,
   output logic [SVL_BITS-1:0] oldDestVector
);
   logic [SVL_BITS-1:0] vecFile_q [4];
   always_ff @(posedge clk)
   begin
      if (rst)
         vecFile_q <= '{default: '0};
      else if (rsp.vecWrEn)
         vecFile_q[rsp.vecWrReg[1:0]] <= destVectorReg;
   end
   // a result written back this cycle is not yet in the file
   assign oldDestVector = (rsp.vecWrEn && rsp.vecWrReg == req.vecReg) ? destVectorReg : vecFile_q[req.vecReg[1:0]];
endmodule : tsm_pipe_model
`default_nettype wire
